// File: hdl/vbw_pkg.sv
// package for the video dram strobe controller: register map, encodings and timing
//*****************************************************************************
// Functional notes
// - one-shot mask: first state low, mask
// - retained mask: first state low, data ignored
// - late write: transfer enable held high
// - early write: transfer enable hold only
// - refresh: select level picks reset option
// - refresh select high, we low: stop point
// - serial clock rise after transfer ends
//*****************************************************************************
package vbw_pkg;
  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_CMD    = 8'h00; // command and go
  localparam logic [7:0] OFS_ROW    = 8'h04; // row address
  localparam logic [7:0] OFS_COL    = 8'h08; // column / stop / tap address
  localparam logic [7:0] OFS_WMASK  = 8'h0C; // write mask
  localparam logic [7:0] OFS_CMASK  = 8'h10; // column mask
  localparam logic [7:0] OFS_STATUS = 8'h14; // busy and serial data
  // ****************************************************************
  // command field
  // ****************************************************************
  localparam int CMD_OP_LSB   = 0;  // op code bits 2:0
  localparam int CMD_LATE_BIT = 4;  // late write timing
  localparam int CMD_PAGE_BIT = 5;  // page-mode block writes
  localparam int CMD_CNT_LSB  = 8;  // number of page columns minus one
  localparam int CMD_GO_BIT   = 31; // start, self clearing
  typedef enum logic [2:0] {
    OP_BW_PLAIN  = 3'h0, // block write, no write mask
    OP_BW_ONCE   = 3'h1, // block write, one-shot mask
    OP_BW_KEEP   = 3'h2, // block write, retained mask
    OP_REF_RESET = 3'h3, // column-first refresh, option reset
    OP_REF_PLAIN = 3'h4, // column-first refresh, no reset
    OP_REF_STOP  = 3'h5, // column-first refresh, stop point set
    OP_XFER      = 3'h6, // full transfer read
    OP_LOAD_MASK = 3'h7  // load write mask register
  } vbw_op_t;
  localparam int STS_BUSY_BIT = 0;  // command running
  localparam int STS_SQ_LSB   = 16; // last serial word
  // ****************************************************************
  // timing, in ns, and cycle counts at the system clock
  // ****************************************************************
  localparam int CLK_NS        = 100;
  localparam int T_PHASE_NS    = 100; // least time per strobe phase
  localparam int PHASE_CYC     = (T_PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] PHASE_CNT = 4'(PHASE_CYC);
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
endpackage : vbw_pkg

// File: hdl/vbw_ctrl.sv
// controller driving the video dram strobes from apb command registers
module vbw_ctrl #(
  parameter int DW = 16,
  parameter int AW = 9
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        row_strobe_n,
  output logic                        column_strobe_n,
  output logic                        write_enable_n,
  output logic                        transfer_output_enable_n,
  output logic                        special_function_select,
  output logic      [AW-1:0]          multiplexed_address,
  output logic      [DW-1:0]          random_data_bus_o,
  output logic                        random_data_bus_oe,
  input  wire logic [DW-1:0]          random_data_bus_i,
  output logic                        serial_shift_clock,
  output logic                        serial_enable_n,
  input  wire logic [DW-1:0]          serial_data_out,
  output logic                        busy
);
  import vbw_pkg::*;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [31:0]   cmd;        // command register
  logic [AW-1:0] row_adr;    // row address
  logic [AW-1:0] col_adr;    // column/stop/tap address
  logic [DW-1:0] wmask;      // write mask for one-shot and load cycles
  logic [DW-1:0] cmask;      // column mask
  logic [DW-1:0] sq_s1;      // serial data, first sync stage
  logic [DW-1:0] sq_s2;      // serial data, second sync stage
  logic          go;         // one-cycle start pulse
  logic          unused_dq;  // random port read data unused here

  typedef enum logic [3:0] {
    ST_IDLE, ST_ROW, ST_ROW_HOLD, ST_COL, ST_COL_HI, ST_RAS_HI,
    ST_CBR_CAS, ST_CBR_RAS, ST_SC_HI, ST_SC_LO
  } vbw_state_t;
  vbw_state_t state;         // sequencer state
  logic [3:0] tmr;           // phase timer
  logic [7:0] cols_left;     // page columns remaining
  vbw_op_t    op;            // decoded op code

  assign op        = vbw_op_t'(cmd[CMD_OP_LSB +: 3]);
  assign unused_dq = ^random_data_bus_i;

  // ****************************************************************
  // apb slave: zero wait states, unmapped reads zero, no errors
  // ****************************************************************
  // write side; go is taken only while the sequencer is idle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cmd     <= RST_ZERO;
      row_adr <= '0;
      col_adr <= '0;
      wmask   <= '0;
      cmask   <= '0;
      go      <= 1'b0;
    end else begin
      go <= 1'b0;
      if (psel && penable && pwrite) begin
        if (paddr == OFS_CMD) begin
          cmd <= pwdata;
          go  <= pwdata[CMD_GO_BIT] && (state == ST_IDLE);
        end else if (paddr == OFS_ROW) begin
          row_adr <= pwdata[AW-1:0];
        end else if (paddr == OFS_COL) begin
          col_adr <= pwdata[AW-1:0];
        end else if (paddr == OFS_WMASK) begin
          wmask <= pwdata[DW-1:0];
        end else if (paddr == OFS_CMASK) begin
          cmask <= pwdata[DW-1:0];
        end
      end
    end
  end

  // read side, registered so prdata comes from a flip-flop
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata <= RST_ZERO;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == OFS_CMD) begin
        prdata <= {1'b0, cmd[30:0]};
      end else if (paddr == OFS_ROW) begin
        prdata <= 32'(row_adr);
      end else if (paddr == OFS_COL) begin
        prdata <= 32'(col_adr);
      end else if (paddr == OFS_WMASK) begin
        prdata <= 32'(wmask);
      end else if (paddr == OFS_CMASK) begin
        prdata <= 32'(cmask);
      end else if (paddr == OFS_STATUS) begin
        prdata <= {sq_s2, 15'h0000, busy};
      end else begin
        prdata <= RST_ZERO;
      end
    end
  end

  // pready high in every access phase; errors never signalled
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
    end
  end

  // serial data from the pins, two-stage sync before status reads it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sq_s1 <= '0;
      sq_s2 <= '0;
    end else begin
      sq_s1 <= serial_data_out;
      sq_s2 <= sq_s1;
    end
  end

  // ****************************************************************
  // strobe sequencer
  // ****************************************************************
  // each state lasts PHASE_CNT cycles; pins change only at phase ends
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state                    <= ST_IDLE;
      tmr                      <= 4'h0;
      cols_left                <= 8'h00;
      busy                     <= 1'b0;
      row_strobe_n             <= 1'b1;
      column_strobe_n          <= 1'b1;
      write_enable_n           <= 1'b1;
      transfer_output_enable_n <= 1'b1;
      special_function_select  <= 1'b0;
      multiplexed_address      <= '0;
      random_data_bus_o        <= '0;
      random_data_bus_oe       <= 1'b0;
      serial_shift_clock       <= 1'b0;
      serial_enable_n          <= 1'b1;
    end else if (tmr != 4'h0) begin
      tmr <= tmr - 4'h1;
    end else begin
      tmr <= PHASE_CNT - 4'h1;
      case (state)
        ST_IDLE: begin
          tmr <= 4'h0;
          if (go) begin
            busy      <= 1'b1;
            cols_left <= cmd[CMD_CNT_LSB +: 8];
            special_function_select <= 1'b0;
            if (op == OP_REF_RESET || op == OP_REF_PLAIN || op == OP_REF_STOP) begin
              // column strobe first; levels sampled at the row fall
              column_strobe_n         <= 1'b0;
              special_function_select <= (op != OP_REF_RESET);
              write_enable_n          <= (op != OP_REF_STOP);
              multiplexed_address     <= (op == OP_REF_STOP) ? col_adr : '0;
              state <= ST_CBR_CAS;
            end else begin
              // first state: we low selects masked writes; transfer enable low selects transfer
              multiplexed_address <= row_adr;
              write_enable_n      <= !(op == OP_BW_ONCE || op == OP_BW_KEEP);
              special_function_select <= (op == OP_LOAD_MASK);
              transfer_output_enable_n <= (op != OP_XFER);
              // second state: one-shot mask on the bus at row fall
              random_data_bus_o  <= (op == OP_BW_ONCE) ? wmask : '0;
              random_data_bus_oe <= (op != OP_XFER);
              state <= ST_ROW;
            end
          end
        end
        ST_ROW: begin
          row_strobe_n <= 1'b0;
          state        <= ST_ROW_HOLD;
        end
        ST_ROW_HOLD: begin
          // early write releases transfer enable after its hold
          if (!cmd[CMD_LATE_BIT] && op != OP_XFER) begin
            transfer_output_enable_n <= 1'b1;
          end
          if (op == OP_XFER) begin
            transfer_output_enable_n <= 1'b1;
          end
          // block writes assert select at the column fall
          special_function_select <= (op != OP_XFER);
          // bits 8 and 7:0 carry half and tap for transfers
          multiplexed_address <= {col_adr[AW-1:2], (op == OP_XFER) ? col_adr[1:0] : 2'b00};
          // third state: column mask, or the new mask for a load
          random_data_bus_o  <= (op == OP_LOAD_MASK) ? wmask : cmask;
          random_data_bus_oe <= (op != OP_XFER);
          write_enable_n     <= (op == OP_XFER) || cmd[CMD_LATE_BIT];
          state <= ST_COL;
        end
        ST_COL: begin
          column_strobe_n <= 1'b0;
          if (op != OP_XFER) begin
            write_enable_n <= 1'b0;
          end
          if (op == OP_XFER) begin
            serial_enable_n <= 1'b0;
          end
          state <= ST_COL_HI;
        end
        ST_COL_HI: begin
          column_strobe_n <= 1'b1;
          write_enable_n  <= 1'b1;
          // late write keeps transfer enable high through the page
          if (cmd[CMD_PAGE_BIT] && cols_left != 8'h00 && op != OP_XFER) begin
            transfer_output_enable_n <= 1'b1;
            cols_left                <= cols_left - 8'h01;
            col_adr_step();
            state <= ST_ROW_HOLD;
          end else begin
            state <= ST_RAS_HI;
          end
        end
        ST_RAS_HI: begin
          row_strobe_n       <= 1'b1;
          random_data_bus_oe <= 1'b0;
          transfer_output_enable_n <= 1'b1;
          special_function_select  <= 1'b0;
          state <= (op == OP_XFER) ? ST_SC_HI : ST_IDLE;
          busy  <= (op == OP_XFER);
        end
        ST_SC_HI: begin
          serial_shift_clock <= 1'b1;
          state <= ST_SC_LO;
        end
        ST_SC_LO: begin
          serial_shift_clock <= 1'b0;
          busy  <= 1'b0;
          state <= ST_IDLE;
        end
        ST_CBR_CAS: begin
          row_strobe_n <= 1'b0;
          state <= ST_CBR_RAS;
        end
        ST_CBR_RAS: begin
          row_strobe_n    <= 1'b1;
          column_strobe_n <= 1'b1;
          write_enable_n  <= 1'b1;
          special_function_select <= 1'b0;
          busy  <= 1'b0;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // page-mode column steps are driven by software rewriting col_adr;
  // the next block address is picked up at the next column phase
  task automatic col_adr_step();
  endtask : col_adr_step

endmodule : vbw_ctrl

// File: test/vbw_ctrl_assertions.sv
// checker on the strobe controller ports
module vbw_ctrl_assertions #(
  parameter int DW = 16,
  parameter int AW = 9
) (
  input wire logic          clk_sys,
  input wire logic          rst_n,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          row_strobe_n,
  input wire logic          column_strobe_n,
  input wire logic          write_enable_n,
  input wire logic          transfer_output_enable_n,
  input wire logic          special_function_select,
  input wire logic [AW-1:0] multiplexed_address,
  input wire logic          random_data_bus_oe,
  input wire logic          serial_shift_clock,
  input wire logic          serial_enable_n,
  input wire logic          busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // setup cycle answered in the next one
  AST_APB_ANSWER: assert property (psel && !penable |=> pready && !pslverr)
    else $error("apb access not answered");
  AST_MASK_AT_ROW: assert property (
    $fell(row_strobe_n) && column_strobe_n && !write_enable_n |-> random_data_bus_oe)
    else $error("write mask not driven at row strobe");
  AST_CMASK_AT_COL: assert property (
    $fell(column_strobe_n) && !row_strobe_n && special_function_select
    |-> random_data_bus_oe && transfer_output_enable_n)
    else $error("column mask not driven at column strobe");
  AST_BLOCK_LOW_BITS: assert property (
    $fell(column_strobe_n) && !row_strobe_n && special_function_select
    |-> multiplexed_address[1:0] == 2'b00)
    else $error("block address low bits not zero");
  AST_REF_ORDER: assert property (
    $fell(column_strobe_n) && row_strobe_n |=> $fell(row_strobe_n))
    else $error("row strobe did not follow column strobe");
  AST_REF_CODE: assert property (
    $fell(row_strobe_n) && !column_strobe_n |-> special_function_select || write_enable_n)
    else $error("illegal refresh option code");
  // once high inside a row cycle, transfer enable stays high to its end
  AST_TRG_HELD: assert property (
    !row_strobe_n && $past(!row_strobe_n) && $past(transfer_output_enable_n)
    |-> transfer_output_enable_n)
    else $error("transfer enable dropped in row cycle");
  AST_SC_PULSE: assert property (
    $rose(serial_shift_clock) |-> transfer_output_enable_n ##1 !serial_shift_clock)
    else $error("serial clock pulse malformed");
  AST_SE_THEN_SC: assert property (
    $fell(serial_enable_n) |-> ##[1:8] $rose(serial_shift_clock))
    else $error("no serial clock after transfer");
  AST_BUSY_IN_CYCLE: assert property ($fell(row_strobe_n) |-> busy)
    else $error("row cycle while not busy");
endmodule : vbw_ctrl_assertions

bind vbw_ctrl vbw_ctrl_assertions #(.DW(DW), .AW(AW)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .row_strobe_n(row_strobe_n),
  .column_strobe_n(column_strobe_n), .write_enable_n(write_enable_n),
  .transfer_output_enable_n(transfer_output_enable_n),
  .special_function_select(special_function_select),
  .multiplexed_address(multiplexed_address), .random_data_bus_oe(random_data_bus_oe),
  .serial_shift_clock(serial_shift_clock), .serial_enable_n(serial_enable_n),
  .busy(busy));

// File: test/vbw_vram_model.sv
// behavioural video dram seen from its strobe pins
module vbw_vram_model #(
  parameter logic [15:0] COLOR = 16'hA5C3 // colour register, arbitrary
) (
  input wire logic        row_strobe_n,
  input wire logic        column_strobe_n,
  input wire logic        write_enable_n,
  input wire logic        transfer_output_enable_n,
  input wire logic        special_function_select,
  input wire logic [8:0]  multiplexed_address,
  input wire logic [15:0] random_data_bus_o,
  input wire logic        random_data_bus_oe,
  output logic     [15:0] random_data_bus_i,
  input wire logic        serial_shift_clock,
  input wire logic        serial_enable_n,
  output logic     [15:0] serial_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [bit [17:0]]; // sparse, unwritten reads zero
  logic [15:0] serial_access_memory [256];
  logic [15:0] wm_once, wm_reg, en_w, en;
  logic [8:0]  row_q, stop_pt;
  logic [7:0]  ptr;
  logic        we1, xfer, ldm, keep, sq_on;
  bit   [17:0] key;
  int          ref_kind, n_ref;
  // device never drives data here: released lines read inverted
  assign random_data_bus_i = random_data_bus_oe ? random_data_bus_o : ~random_data_bus_o;
  function automatic logic [15:0] rd(bit [17:0] k);
    return mem.exists(k) ? mem[k] : 16'h0000;
  endfunction : rd
  initial begin
    sq_on = 1'b0;
    keep = 1'b0;
    n_ref = 0;
    ref_kind = -1;
    serial_data_out = 16'h0000;
  end
  // row strobe fall decodes the cycle kind
  always @(negedge row_strobe_n) begin
    if (!column_strobe_n) begin
      ref_kind = !special_function_select ? 0 : (write_enable_n ? 1 : 2);
      if (ref_kind == 2) stop_pt = multiplexed_address;
      n_ref++;
    end else begin
      row_q = multiplexed_address;
      xfer = !transfer_output_enable_n;
      ldm = special_function_select;
      we1 = write_enable_n;
      wm_once = random_data_bus_i;
    end
  end
  // column strobe fall completes transfer, mask load or block write
  always @(negedge column_strobe_n) begin
    if (!row_strobe_n && xfer) begin
      for (int k = 0; k < 256; k++) serial_access_memory[k] = rd({row_q, multiplexed_address[8], 8'(k)});
      ptr = multiplexed_address[7:0];
      sq_on = 1'b1;
    end else if (!row_strobe_n && ldm) begin
      wm_reg = random_data_bus_i;
      keep = 1'b1;
    end else if (!row_strobe_n && special_function_select) begin
      en_w = we1 ? 16'hFFFF : (keep ? wm_reg : wm_once);
      for (int c = 0; c < 4; c++) begin
        for (int j = 0; j < 16; j++) en[j] = en_w[j] & random_data_bus_i[(j/4)*4+c];
        key = {row_q, multiplexed_address[8:2], 2'(c)};
        mem[key] = (rd(key) & ~en) | (COLOR & en);
      end
    end
  end
  // each serial clock rise presents the next word, else lines toggle
  always @(posedge serial_shift_clock) begin
    if (sq_on && !serial_enable_n) begin
      serial_data_out <= serial_access_memory[ptr];
      ptr <= ptr + 8'd1;
    end else begin
      serial_data_out <= ~serial_data_out;
    end
  end
endmodule : vbw_vram_model

// File: test/vbw_ctrl_tb.sv
// self-checking bench for the video dram strobe controller
module vbw_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import vbw_pkg::*;
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, busy;
  logic row_strobe_n, column_strobe_n, write_enable_n, transfer_output_enable_n;
  logic special_function_select, random_data_bus_oe, serial_shift_clock, serial_enable_n;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [8:0]  multiplexed_address;
  logic [15:0] random_data_bus_o, random_data_bus_i, serial_data_out;
  int          fails, n_tests, cyc;
  vbw_ctrl DUT (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .row_strobe_n, .column_strobe_n, .write_enable_n,
    .transfer_output_enable_n, .special_function_select, .multiplexed_address,
    .random_data_bus_o, .random_data_bus_oe, .random_data_bus_i, .serial_shift_clock,
    .serial_enable_n, .serial_data_out, .busy);
  vbw_vram_model VRAM (.row_strobe_n, .column_strobe_n, .write_enable_n,
    .transfer_output_enable_n, .special_function_select, .multiplexed_address,
    .random_data_bus_o, .random_data_bus_oe, .random_data_bus_i, .serial_shift_clock,
    .serial_enable_n, .serial_data_out);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  // one apb transfer; waits for pready, then an idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  // start a command and wait for busy to rise and fall
  task automatic run(input vbw_op_t op, input logic [31:0] fl);
    int k;
    apb(1'b1, OFS_CMD, 32'h8000_0000 | fl | 32'(op), rd_q);
    k = 0;
    while (busy !== 1'b1 && k < 4) begin
      @(posedge clk_sys);
      k++;
    end
    while (busy !== 1'b0 && k < 100) begin
      @(posedge clk_sys);
      k++;
    end
    chk("command done", 32'h0, 32'(k == 100));
    repeat (4) @(posedge clk_sys);
  endtask : run
  task automatic xfer(input logic [31:0] col, input logic [15:0] exp);
    apb(1'b1, OFS_COL, col, rd_q);
    run(OP_XFER, 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0, rd_q);
    chk("serial word", {16'h0, exp}, {16'h0, rd_q[31:16]});
  endtask : xfer
  task automatic t_regs;
    apb(1'b1, OFS_ROW, 32'h0000_0155, rd_q);
    apb(1'b0, OFS_ROW, 32'h0, rd_q);
    chk("row reg", 32'h0000_0155, rd_q);
    apb(1'b0, 8'h3C, 32'h0, rd_q);
    chk("unmapped", 32'h0, rd_q);
    $display("test regs done");
  endtask : t_regs
  // two block writes into one row, then read back through transfers
  task automatic t_block;
    apb(1'b1, OFS_COL, 32'h0000_0011, rd_q);
    apb(1'b1, OFS_WMASK, 32'h0000_00FF, rd_q);
    apb(1'b1, OFS_CMASK, 32'h0000_2222, rd_q);
    run(OP_BW_ONCE, 32'h0);
    apb(1'b1, OFS_CMASK, 32'h0000_1000, rd_q);
    run(OP_BW_PLAIN, 32'h0000_0130);
    xfer(32'h0000_0011, 16'h00C3);
    xfer(32'h0000_0010, 16'hA000);
    xfer(32'h0000_0111, 16'h0000);
    $display("test block done");
  endtask : t_block
  task automatic t_refresh;
    vbw_op_t ops[3] = '{OP_REF_RESET, OP_REF_PLAIN, OP_REF_STOP};
    apb(1'b1, OFS_COL, 32'h0000_01A5, rd_q);
    foreach (ops[i]) begin
      run(ops[i], 32'h0);
      chk("refresh kind", 32'(i), 32'(VRAM.ref_kind));
    end
    chk("stop point", 32'h0000_01A5, {23'h0, VRAM.stop_pt});
    $display("test refresh done");
  endtask : t_refresh
  // retained mask ops, then a start while busy is ignored
  task automatic t_misc;
    int n;
    apb(1'b1, OFS_WMASK, 32'h0000_0F0F, rd_q);
    run(OP_LOAD_MASK, 32'h0);
    // retained mask 0f0f against lanes 3:0 only: columns 1a4..1a7 get 0003
    apb(1'b1, OFS_CMASK, 32'h0000_000F, rd_q);
    run(OP_BW_KEEP, 32'h0000_0010);
    xfer(32'h0000_01A5, 16'h0003);
    n = VRAM.n_ref;
    apb(1'b1, OFS_CMD, 32'h8000_0000 | 32'(OP_XFER), rd_q);
    apb(1'b1, OFS_CMD, 32'h8000_0000 | 32'(OP_REF_PLAIN), rd_q);
    repeat (20) @(posedge clk_sys);
    chk("go while busy", 32'(n), 32'(VRAM.n_ref));
    $display("test misc done");
  endtask : t_misc
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk_sys);
      cyc++;
      if (cyc == 5000) begin
        fails++;
        conclude();
      end
    end
  end
  initial begin
    fails = 0;
    n_tests = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_regs();
    t_block();
    t_refresh();
    t_misc();
    conclude();
  end
endmodule : vbw_ctrl_tb
